/* File: rtl/pdmux_top.sv */
// Port D pin function mux with its select registers on an AXI4-Lite slave
//
// How it works
// - Sixteen-bit read/write select register, one function bit per port D pin.
// - ROM off, 8-bit area 0: low eight pins are always data bus.
// - ROM off, 16-bit area 0: all sixteen pins are data bus.
// - ROM on: each select bit picks data bus or general I/O.
// - Single-chip: all pins general I/O, select bits ignored.
// - Power-on reset and hardware standby clear select; watchdog reset does not.
// - Sleep and software standby leave the select register untouched.
// - Bits 15..10: zero general I/O, one data bus, in 8-bit and ROM-on modes.
// - In general I/O, direction bit one drives output, zero makes input.
// - Bits 9 and 8 encode like the upper bits.
// - Bits 7..0 ignored with ROM off; with ROM on, one selects data bus.
`timescale 1ns/100ps
`include "pdmux_regs.svh"

module pdmux_top
	import pdmux_pkg::*;
#(
	parameter int PINS = 16
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic watchdog_timer_reset,
	input wire logic hw_standby,
	input wire logic single_chip_mode,
	input wire logic rom_enabled,
	input wire logic area0_bus_16bit,
	input wire pdmux_pkg::pdmux_addr_t s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire pdmux_pkg::pdmux_addr_t s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire pdmux_pkg::pdmux_pins_t gpio_dout,
	output pdmux_pkg::pdmux_pins_t gpio_din,
	input wire pdmux_pkg::pdmux_pins_t bus_dout,
	input wire logic bus_oe,
	output pdmux_pkg::pdmux_pins_t bus_din,
	input wire pdmux_pkg::pdmux_pins_t pad_in,
	output pdmux_pkg::pdmux_pins_t pad_out,
	output pdmux_pkg::pdmux_pins_t pad_oe_n,
	output pdmux_pkg::pdmux_pins_t pin_is_bus
);

	import pdmux_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// State

	localparam pdmux_state_s STATE_RESET = '{
		wr_state: PDMUX_WR_IDLE,
		rd_state: PDMUX_RD_IDLE,
		aw_got: 1'b0,
		w_got: 1'b0,
		awaddr: '0,
		wdata: '0,
		wstrb: '0,
		bresp: `PDMUX_RESP_OKAY,
		rdata: '0,
		rresp: `PDMUX_RESP_OKAY,
		func_sel: `PDMUX_FUNC_SEL_RESET,
		dir_sel: `PDMUX_DIR_SEL_RESET,
		bus_mask: `PDMUX_NO_PINS_BUS
	};

	pdmux_state_s s;
	pdmux_state_s next_s;
	logic aw_take;
	logic w_take;
	logic write_go;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Byte-lane merge of a 16-bit register
	function automatic pdmux_pins_t merge_lanes(
		input pdmux_pins_t old_val,
		input logic [31:0] data,
		input logic [3:0] strb
	);
		pdmux_pins_t res;
		res = old_val;
		// Upper half-word lanes have no register bits behind them
		if (strb[0])
			res[7:0] = data[7:0];
		if (strb[1])
			res[15:8] = data[15:8];
		return res;
	endfunction : merge_lanes

	// Which pins the operating mode hands to the data bus
	function automatic pdmux_pins_t resolve_mask(
		input logic single_chip,
		input logic rom_on,
		input logic wide,
		input pdmux_pins_t sel
	);
		pdmux_pins_t res;
		// Single-chip strap outranks the ROM and width straps
		if (single_chip)
			res = `PDMUX_NO_PINS_BUS;
		else if (rom_on)
			res = sel;
		else if (wide)
			res = `PDMUX_ALL_PINS_BUS;
		else
			res = sel | `PDMUX_LOW_PINS_BUS;
		return res;
	endfunction : resolve_mask

	// Read decode
	function automatic logic [31:0] read_word(
		input pdmux_addr_t addr,
		input pdmux_state_s st,
		input logic single_chip,
		input logic rom_on,
		input logic wide
	);
		logic [31:0] res;
		res = '0;
		unique case (addr)
			`PDMUX_OFS_FUNC_SEL: res[15:0] = st.func_sel;
			`PDMUX_OFS_DIR_SEL: res[15:0] = st.dir_sel;
			// Live straps beside the resolved mask
			`PDMUX_OFS_STATUS:
			begin
				res[15:0] = st.bus_mask;
				res[`PDMUX_ST_SINGLE_BIT] = single_chip;
				res[`PDMUX_ST_ROM_BIT] = rom_on;
				res[`PDMUX_ST_WIDE_BIT] = wide;
			end
			default: res = '0;
		endcase
		return res;
	endfunction : read_word

	function automatic logic addr_mapped(input pdmux_addr_t addr);
		return (addr == `PDMUX_OFS_FUNC_SEL) || (addr == `PDMUX_OFS_DIR_SEL)
			|| (addr == `PDMUX_OFS_STATUS);
	endfunction : addr_mapped

	////////////////////////////////////////////////////////////////////////////
	// Bus handshakes

	assign s_axi_awready = (s.wr_state == PDMUX_WR_IDLE) && !s.aw_got;
	assign s_axi_wready = (s.wr_state == PDMUX_WR_IDLE) && !s.w_got;
	assign s_axi_bvalid = (s.wr_state == PDMUX_WR_RESP);
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = (s.rd_state == PDMUX_RD_IDLE);
	assign s_axi_rvalid = (s.rd_state == PDMUX_RD_RESP);
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;

	// Each channel taken once per write, in either order
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		next_s = s;
		write_go = 1'b0;

		// Address and data may arrive in either order
		if (aw_take)
		begin
			next_s.aw_got = 1'b1;
			next_s.awaddr = s_axi_awaddr;
		end
		if (w_take)
		begin
			next_s.w_got = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end

		// Commit once address and data are both held
		unique case (s.wr_state)
			PDMUX_WR_IDLE:
			begin
				write_go = next_s.aw_got && next_s.w_got;
				if (write_go)
				begin
					next_s.aw_got = 1'b0;
					next_s.w_got = 1'b0;
					next_s.wr_state = PDMUX_WR_RESP;
					next_s.bresp = `PDMUX_RESP_OKAY;
					if (next_s.awaddr == `PDMUX_OFS_FUNC_SEL)
						next_s.func_sel = merge_lanes(s.func_sel, next_s.wdata,
							next_s.wstrb);
					else if (next_s.awaddr == `PDMUX_OFS_DIR_SEL)
						next_s.dir_sel = merge_lanes(s.dir_sel, next_s.wdata,
							next_s.wstrb);
					else if (!addr_mapped(next_s.awaddr))
						next_s.bresp = `PDMUX_RESP_SLVERR;
				end
			end
			PDMUX_WR_RESP:
			begin
				if (s_axi_bready)
					next_s.wr_state = PDMUX_WR_IDLE;
			end
			default: next_s.wr_state = PDMUX_WR_IDLE;
		endcase

		// Read word captured at the address edge, held until taken
		unique case (s.rd_state)
			PDMUX_RD_IDLE:
			begin
				if (s_axi_arvalid)
				begin
					next_s.rd_state = PDMUX_RD_RESP;
					next_s.rdata = read_word(s_axi_araddr, s, single_chip_mode,
						rom_enabled, area0_bus_16bit);
					next_s.rresp = addr_mapped(s_axi_araddr) ? `PDMUX_RESP_OKAY
						: `PDMUX_RESP_SLVERR;
				end
			end
			PDMUX_RD_RESP:
			begin
				if (s_axi_rready)
					next_s.rd_state = PDMUX_RD_IDLE;
			end
			default: next_s.rd_state = PDMUX_RD_IDLE;
		endcase

		// Hardware standby holds the select registers cleared
		if (hw_standby)
		begin
			next_s.func_sel = `PDMUX_FUNC_SEL_RESET;
			next_s.dir_sel = `PDMUX_DIR_SEL_RESET;
		end

		// Watchdog reset restarts the bus side only; selects are kept
		if (watchdog_timer_reset)
		begin
			next_s.wr_state = PDMUX_WR_IDLE;
			next_s.rd_state = PDMUX_RD_IDLE;
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
		end

		// Sleep and software standby have no effect here: nothing else clears
		next_s.bus_mask = resolve_mask(single_chip_mode, rom_enabled,
			area0_bus_16bit, next_s.func_sel);
	end

	always_ff @(posedge aclk)
	begin
		// Power-on reset only; watchdog restart is handled above
		if (!aresetn)
			s <= STATE_RESET;
		else
			s <= next_s;
	end

	////////////////////////////////////////////////////////////////////////////
	// Resolved mask

	// Registered, so pad cells switch one edge after the mask
	assign pin_is_bus = s.bus_mask;

	////////////////////////////////////////////////////////////////////////////
	// Pin cells

	for (genvar i = 0; i < PINS; i++)
	begin : g_pin
		// One cell per pin, all sharing the single bus enable
		pdmux_pin u_pin (
			.aclk(aclk),
			.aresetn(aresetn),
			.is_bus(s.bus_mask[i]),
			.dir_out(s.dir_sel[i]),
			.gpio_dout(gpio_dout[i]),
			.bus_dout(bus_dout[i]),
			.bus_oe(bus_oe),
			.pad_in(pad_in[i]),
			.pad_out(pad_out[i]),
			.pad_oe_n(pad_oe_n[i]),
			.gpio_din(gpio_din[i]),
			.bus_din(bus_din[i])
		);
	end

endmodule : pdmux_top

/* File: rtl/pdmux_regs.svh */
// Register offsets, field positions and reset values of the port D function mux
`ifndef PDMUX_REGS_SVH
`define PDMUX_REGS_SVH

// Byte offsets on the register bus
`define PDMUX_OFS_FUNC_SEL 8'h00
`define PDMUX_OFS_DIR_SEL 8'h04
`define PDMUX_OFS_STATUS 8'h08

// Reset values
`define PDMUX_FUNC_SEL_RESET 16'h0000
`define PDMUX_DIR_SEL_RESET 16'h0000

// Pin groups of the select register
`define PDMUX_LOW_PINS_BUS 16'h00FF
`define PDMUX_ALL_PINS_BUS 16'hFFFF
`define PDMUX_NO_PINS_BUS 16'h0000

// Status word fields: bits 15..0 hold the resolved data-bus mask
`define PDMUX_ST_SINGLE_BIT 16
`define PDMUX_ST_ROM_BIT 17
`define PDMUX_ST_WIDE_BIT 18

// Bus responses
`define PDMUX_RESP_OKAY 2'h0
`define PDMUX_RESP_SLVERR 2'h2

`endif

/* File: rtl/pdmux_pkg.sv */
// Types shared by the port D function mux and its pin cell
package pdmux_pkg;

	localparam int PDMUX_ADDR_W = 8;
	localparam int PDMUX_PINS = 16;

	typedef logic [PDMUX_PINS-1:0] pdmux_pins_t;
	typedef logic [PDMUX_ADDR_W-1:0] pdmux_addr_t;

	typedef enum logic [1:0] {
		PDMUX_WR_IDLE = 2'b01,
		PDMUX_WR_RESP = 2'b10
	} pdmux_wr_e;

	typedef enum logic [1:0] {
		PDMUX_RD_IDLE = 2'b01,
		PDMUX_RD_RESP = 2'b10
	} pdmux_rd_e;

	typedef struct packed {
		pdmux_wr_e wr_state;
		pdmux_rd_e rd_state;
		logic aw_got;
		logic w_got;
		pdmux_addr_t awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [1:0] bresp;
		logic [31:0] rdata;
		logic [1:0] rresp;
		pdmux_pins_t func_sel;
		pdmux_pins_t dir_sel;
		pdmux_pins_t bus_mask;
	} pdmux_state_s;

	typedef struct packed {
		logic pad_out;
		logic pad_oe_n;
		logic gpio_din;
		logic bus_din;
	} pdmux_pin_s;

endpackage : pdmux_pkg

/* File: rtl/pdmux_pin.sv */
// One multiplexed port D pin: steers the pad between general I/O and data bus
`timescale 1ns/100ps

module pdmux_pin
	import pdmux_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic is_bus,
	input wire logic dir_out,
	input wire logic gpio_dout,
	input wire logic bus_dout,
	input wire logic bus_oe,
	input wire logic pad_in,
	output logic pad_out,
	output logic pad_oe_n,
	output logic gpio_din,
	output logic bus_din
);

	pdmux_pin_s s;
	pdmux_pin_s next_s;

	always_comb
	begin
		next_s = s;
		next_s.gpio_din = pad_in;
		next_s.bus_din = pad_in;
		if (is_bus)
		begin
			// Bus controller owns value and enable
			next_s.pad_out = bus_dout;
			next_s.pad_oe_n = ~bus_oe;
		end
		else
		begin
			// Direction bit: one drives, zero listens
			next_s.pad_out = gpio_dout;
			next_s.pad_oe_n = ~dir_out;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= '{pad_out: 1'b0, pad_oe_n: 1'b1, gpio_din: 1'b0, bus_din: 1'b0};
		else
			s <= next_s;
	end

	assign pad_out = s.pad_out;
	assign pad_oe_n = s.pad_oe_n;
	assign gpio_din = s.gpio_din;
	assign bus_din = s.bus_din;

endmodule : pdmux_pin

/* File: verification/pdmux_pad_load.sv */
// Pad load model for the port D pins
`timescale 1ns/100ps

module pdmux_pad_load
	import pdmux_pkg::*;
(
	input wire logic aclk,
	input wire pdmux_pkg::pdmux_pins_t pad_out,
	input wire pdmux_pkg::pdmux_pins_t pad_oe_n,
	output pdmux_pkg::pdmux_pins_t pad_in
);
	pdmux_pins_t float_pat = 16'h5A5A;

	// Released pads wiggle every cycle
	always @(posedge aclk)
		float_pat <= ~float_pat;

	assign pad_in = (pad_out & ~pad_oe_n) | (float_pat & pad_oe_n);
endmodule : pdmux_pad_load

/* File: verification/pdmux_properties.sv */
// Port-level properties of the port D function mux
`timescale 1ns/100ps

module pdmux_properties
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic watchdog_timer_reset,
	input wire logic hw_standby,
	input wire logic single_chip_mode,
	input wire logic rom_enabled,
	input wire logic area0_bus_16bit,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [15:0] bus_dout,
	input wire logic bus_oe,
	input wire logic [15:0] bus_din,
	input wire logic [15:0] gpio_din,
	input wire logic [15:0] pad_in,
	input wire logic [15:0] pad_out,
	input wire logic [15:0] pad_oe_n,
	input wire logic [15:0] pin_is_bus
);
	wire ext_mode = !single_chip_mode && !rom_enabled;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn || watchdog_timer_reset);

	sequence stby_rom;
		hw_standby && rom_enabled && !single_chip_mode;
	endsequence

	////////////////////////////////////////
	a_single_no_bus: assert property (single_chip_mode |=> pin_is_bus == 16'h0000)
		else $error("bus pin in single-chip mode");
	a_wide_all_bus: assert property (ext_mode && area0_bus_16bit |=> pin_is_bus == 16'hFFFF)
		else $error("wide mode mask wrong");
	a_narrow_low: assert property (ext_mode && !area0_bus_16bit |=>
		pin_is_bus[7:0] == 8'hFF) else $error("narrow mode low pins wrong");
	a_bus_pad_oe: assert property (1 |=> (pad_oe_n & $past(pin_is_bus)) ==
		($past(pin_is_bus) & {16{!$past(bus_oe)}})) else $error("bus pin enable wrong");
	a_bus_pad_data: assert property ($past(bus_oe) |-> (pad_out & $past(pin_is_bus)) ==
		($past(bus_dout) & $past(pin_is_bus))) else $error("bus pin data wrong");
	a_pad_sampled: assert property ($past(aresetn) |-> gpio_din == $past(pad_in)
		&& bus_din == $past(pad_in)) else $error("pad input not sampled");
	a_stby_clear: assert property (stby_rom [*2] |=> pin_is_bus == 16'h0000)
		else $error("standby left select bits set");
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
endmodule : pdmux_properties

/* File: verification/testbench.sv */
// Self-checking bench for the port D function mux
`timescale 1ns/100ps
`include "pdmux_regs.svh"

module testbench;
	import pdmux_pkg::*;
	logic aclk = 0, aresetn = 0, watchdog_timer_reset = 0, hw_standby = 0;
	logic single_chip_mode = 1, rom_enabled = 0, area0_bus_16bit = 0;
	pdmux_addr_t s_axi_awaddr = 0, s_axi_araddr = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, bus_oe = 1;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h3;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	pdmux_pins_t gpio_dout = 0, bus_dout = 16'h3C5A;
	pdmux_pins_t gpio_din, bus_din, pad_in, pad_out, pad_oe_n, pin_is_bus;
	int fail_count = 0, cmp_count = 0;
	logic [2:0] mode_tab [4] = '{3'h4, 3'h2, 3'h0, 3'h1};
	pdmux_pins_t exp_tab [4] = '{16'h0000, 16'hA5C3, 16'hA5FF, 16'hFFFF};

	always #25 aclk = ~aclk;

	pdmux_top pdmux_top_i (.*);
	pdmux_pad_load pdmux_pad_load_i (.aclk, .pad_out, .pad_oe_n, .pad_in);

	////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e)
		begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic wr(input pdmux_addr_t a, input logic [15:0] d, input logic [3:0] sb,
		input logic [1:0] er);
		logic ad, wd;
		ad = 0;
		wd = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_wstrb <= sb;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			if (!ad && s_axi_awready)
			begin
				ad = 1;
				s_axi_awvalid <= 0;
			end
			if (!wd && s_axi_wready)
			begin
				wd = 1;
				s_axi_wvalid <= 0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 0;
		chk("bresp", {30'h0, er}, s_axi_bresp);
	endtask : wr

	task automatic rd(input pdmux_addr_t a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 0;
		chk("rdata", e, s_axi_rdata);
		chk("rresp", {30'h0, er}, s_axi_rresp);
	endtask : rd

	task automatic end_sim();
		$display("Mismatches %0d of %0d comparisons", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		rd(`PDMUX_OFS_FUNC_SEL, 0, 0);
		rd(`PDMUX_OFS_DIR_SEL, 0, 0);
		wr(`PDMUX_OFS_FUNC_SEL, 16'hA5C3, 4'h3, `PDMUX_RESP_OKAY);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge aclk);
			{single_chip_mode, rom_enabled, area0_bus_16bit} <= mode_tab[i];
			repeat (2) @(posedge aclk);
			chk("pin_is_bus", exp_tab[i], pin_is_bus);
		end
		repeat (2) @(posedge aclk);
		chk("pad_out", 16'h3C5A, pad_out);
		chk("pad_oe_n", 16'h0000, pad_oe_n);
		chk("bus_din", 16'h3C5A, bus_din);
		bus_oe <= 0;
		repeat (2) @(posedge aclk);
		chk("pad_oe_n", 16'hFFFF, pad_oe_n);
		@(posedge aclk);
		watchdog_timer_reset <= 1;
		@(posedge aclk);
		watchdog_timer_reset <= 0;
		rd(`PDMUX_OFS_FUNC_SEL, 32'hA5C3, 0);
		{single_chip_mode, rom_enabled, area0_bus_16bit} <= 3'h4;
		gpio_dout <= 16'h0008;
		wr(`PDMUX_OFS_DIR_SEL, 16'h0008, 4'h3, `PDMUX_RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk("pad_oe_n", 16'hFFF7, pad_oe_n);
		chk("pad_out", 16'h0008, pad_out & 16'h0008);
		chk("gpio_din", 16'h0008, gpio_din & 16'h0008);
		@(posedge aclk);
		hw_standby <= 1;
		{single_chip_mode, rom_enabled, area0_bus_16bit} <= 3'h2;
		repeat (2) @(posedge aclk);
		hw_standby <= 0;
		rd(`PDMUX_OFS_FUNC_SEL, 0, 0);
		rd(`PDMUX_OFS_DIR_SEL, 0, 0);
		wr(`PDMUX_OFS_FUNC_SEL, 16'hBE5A, 4'h2, `PDMUX_RESP_OKAY);
		wr(`PDMUX_OFS_STATUS, 16'hFFFF, 4'h3, `PDMUX_RESP_OKAY);
		wr(8'h0C, 16'hFFFF, 4'h3, `PDMUX_RESP_SLVERR);
		rd(`PDMUX_OFS_FUNC_SEL, 32'hBE00, 0);
		rd(`PDMUX_OFS_STATUS, (32'h1 << `PDMUX_ST_ROM_BIT) | 32'hBE00, 0);
		rd(8'h0C, 0, 2'h2);
		end_sim();
	end

	initial
	begin
		#200000;
		fail_count++;
		end_sim();
	end
endmodule : testbench

bind pdmux_top pdmux_properties pdmux_properties_i (.*);
